// file: hdl/agd_pkg.sv
package agd_pkg;

   // Register addresses on the control port.
   localparam logic [7:0] ADDR_GAIN = 8'h21;
   localparam logic [7:0] ADDR_LEFT_DEB = 8'h22;
   localparam logic [7:0] ADDR_RIGHT_DEB = 8'h23;

   // Field layout of a debounce register.
   localparam int NOISE_LSB = 3;
   localparam int NOISE_W = 5;
   localparam int SIG_LSB = 0;
   localparam int SIG_W = 3;

   // Reset values.
   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [7:0] DEB_RST = 8'h00;

   // Time base: one tick is half a millisecond.
   localparam int CLK_PERIOD_PS = 10_000;
   localparam int TICK_TIME_PS = 500_000_000;
   localparam int TICK_CYC = TICK_TIME_PS / CLK_PERIOD_PS;

   // Long noise codes count in steps of 64 ms.
   localparam int LONG_STEP_MS = 64;
   localparam int TICKS_PER_MS = 2;
   localparam logic [11:0] LONG_STEP_TICKS = 12'(LONG_STEP_MS * TICKS_PER_MS);
   localparam logic [4:0] LONG_FIRST_CODE = 5'h08;
   localparam int TICK_W = 12;

   // Debounce length in ticks for a code; codes 1..7 double from one tick.
   function automatic logic [11:0] deb_ticks(input logic [4:0] code);
      logic [11:0] t;
      t = 12'h000;
      if (code == 5'h00) begin
         t = 12'h000;
      end else if (code < LONG_FIRST_CODE) begin
         t = 12'h001 << (code - 5'h01);
      end else begin
         t = 12'(12'(code - 5'h07) * LONG_STEP_TICKS);
      end
      return t;
   endfunction

endpackage

// file: hdl/agd_tick.sv
`timescale 1ns/10ps
`default_nettype none

// Half-millisecond tick divider; in double rate audio mode it runs twice as fast.
module agd_tick #(
   parameter int PERIOD = agd_pkg::TICK_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic double_rate_audio_mode,
   output logic tick_r
);

   localparam int CW = $clog2(PERIOD + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
   localparam logic [CW-1:0] LAST_DRA = CW'(PERIOD / 2 - 1);
   localparam logic [CW-1:0] HELD_MIN = CW'(PERIOD / 2 + 1);

   generate
      if (PERIOD < 4) begin : g_chk
         $error("agd_tick: PERIOD must be at least 4");
      end
   endgenerate

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] last;
   logic [CW-1:0] dra_held_r;

   assign last = double_rate_audio_mode ? LAST_DRA : LAST;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r >= last) begin
         cnt_r <= '0;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // Counts edges with the mode held high; only the period check reads it.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dra_held_r <= '0;
      end else if (!double_rate_audio_mode) begin
         dra_held_r <= '0;
      end else if (dra_held_r != HELD_MIN) begin
         dra_held_r <= dra_held_r + 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   tick_single_a: assert property (tick_r |=> !tick_r)
      else $error("tick lasted more than one cycle");
   tick_dra_a: assert property (tick_r && dra_held_r == HELD_MIN
      |-> $past(tick_r, PERIOD / 2))
      else $error("tick period wrong in double rate audio mode");

endmodule
`default_nettype wire

// file: hdl/agd_debounce.sv
`timescale 1ns/10ps
`default_nettype none

// One channel: the detect status follows the raw noise level only after it has
// held for the selected number of ticks.
module agd_debounce (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   input wire logic noise_raw,
   input wire logic [11:0] noise_ticks,
   input wire logic [11:0] sig_ticks,
   output logic status_r
);

   logic [11:0] cnt_r;
   logic [11:0] target;

   // Going to noise uses the noise time, going back to signal the signal time.
   assign target = noise_raw ? noise_ticks : sig_ticks;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         status_r <= 1'b0;
         cnt_r <= 12'h000;
      end else if (noise_raw == status_r) begin
         cnt_r <= 12'h000;
      end else if (target == 12'h000) begin
         status_r <= noise_raw;
         cnt_r <= 12'h000;
      end else if (tick) begin
         if (cnt_r + 12'h001 >= target) begin
            status_r <= noise_raw;
            cnt_r <= 12'h000;
         end else begin
            cnt_r <= cnt_r + 12'h001;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence raw_moves_s;
      noise_raw != status_r;
   endsequence

   sequence raw_held_s;
      $stable(noise_raw) [*2];
   endsequence

   deb_zero_a: assert property (raw_moves_s ##0 (target == 12'h000)
      |=> status_r == $past(noise_raw))
      else $error("zero debounce did not pass through at once");
   deb_hold_a: assert property ($changed(status_r) |-> status_r == $past(noise_raw))
      else $error("status changed without raw level");
   deb_wait_a: assert property (raw_held_s ##0 raw_moves_s
      ##0 (target != 12'h000 && !tick) |=> $stable(status_r))
      else $error("status moved before debounce elapsed");

endmodule
`default_nettype wire

// file: hdl/agd_top.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - Right gain readback, read-only, half-dB code.
// - Code zero is 0 dB, resets to zero.
// - Left noise debounce field, bits seven to three.
// - High noise codes count in 64 ms steps.
// - Left signal debounce field, bits two to zero.
// - Right noise debounce field, same encoding.
// - Right signal debounce field, same encoding.
// - Debounce fields read/write, reset to zero.
// - Times differ in double rate audio mode.
// - Detect status one when power below threshold.
module agd_top #(
   parameter int TICK_CYC = agd_pkg::TICK_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   output logic reg_rvalid_r,
   input wire logic [7:0] agc_gain,
   input wire logic agc_gain_upd,
   input wire logic double_rate_audio_mode,
   input wire logic [1:0] noise_raw,
   output logic [1:0] sig_det_status
);

   localparam int NCH = 2;

   logic [7:0] gain_r;
   logic [7:0] deb_r [NCH];
   logic tick;
   logic [NCH-1:0] status_int;

   // Shared decode of the control port address.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      return a == target;
   endfunction

   // The gain word is taken whole on the update strobe so a read never tears.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gain_r <= agd_pkg::GAIN_RST;
      end else if (agc_gain_upd) begin
         gain_r <= agc_gain;
      end
   end

   // Debounce registers: channel 0 left, channel 1 right.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         deb_r[0] <= agd_pkg::DEB_RST;
         deb_r[1] <= agd_pkg::DEB_RST;
      end else if (reg_wr) begin
         if (hit(reg_addr, agd_pkg::ADDR_LEFT_DEB)) begin
            deb_r[0] <= reg_wdata;
         end
         if (hit(reg_addr, agd_pkg::ADDR_RIGHT_DEB)) begin
            deb_r[1] <= reg_wdata;
         end
      end
   end

   // Read port: one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd) begin
            if (hit(reg_addr, agd_pkg::ADDR_GAIN)) begin
               reg_rdata_r <= gain_r;
            end else if (hit(reg_addr, agd_pkg::ADDR_LEFT_DEB)) begin
               reg_rdata_r <= deb_r[0];
            end else if (hit(reg_addr, agd_pkg::ADDR_RIGHT_DEB)) begin
               reg_rdata_r <= deb_r[1];
            end else begin
               reg_rdata_r <= 8'h00;
            end
         end
      end
   end

   agd_tick #(
      .PERIOD(TICK_CYC)
   ) u_tick (
      .mclk(mclk),
      .rst(rst),
      .double_rate_audio_mode(double_rate_audio_mode),
      .tick_r(tick)
   );

   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
         agd_debounce u_deb (
            .mclk(mclk),
            .rst(rst),
            .tick(tick),
            .noise_raw(noise_raw[ch]),
            .noise_ticks(agd_pkg::deb_ticks(
               deb_r[ch][agd_pkg::NOISE_LSB +: agd_pkg::NOISE_W])),
            .sig_ticks(agd_pkg::deb_ticks(
               5'(deb_r[ch][agd_pkg::SIG_LSB +: agd_pkg::SIG_W]))),
            .status_r(status_int[ch])
         );
      end
   endgenerate

   assign sig_det_status = status_int;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   gain_capture_a: assert property (agc_gain_upd |=> gain_r == $past(agc_gain))
      else $error("gain not captured on update");
   gain_ro_a: assert property (!agc_gain_upd |=> $stable(gain_r))
      else $error("gain readback changed without update");
   gain_read_a: assert property (reg_rd && hit(reg_addr, agd_pkg::ADDR_GAIN)
      |=> reg_rvalid_r && reg_rdata_r == $past(gain_r))
      else $error("gain read returned wrong value");
   left_write_a: assert property (reg_wr && hit(reg_addr, agd_pkg::ADDR_LEFT_DEB)
      |=> deb_r[0] == $past(reg_wdata))
      else $error("left debounce write lost");
   right_write_a: assert property (reg_wr && hit(reg_addr, agd_pkg::ADDR_RIGHT_DEB)
      |=> deb_r[1] == $past(reg_wdata))
      else $error("right debounce write lost");
   deb_keep_a: assert property (!reg_wr |=> $stable(deb_r[0]) && $stable(deb_r[1]))
      else $error("debounce field changed without write");
   deb_read_a: assert property (reg_rd && hit(reg_addr, agd_pkg::ADDR_RIGHT_DEB)
      |=> reg_rdata_r == $past(deb_r[1]))
      else $error("right debounce read wrong");
   unmapped_a: assert property (reg_rd && !hit(reg_addr, agd_pkg::ADDR_GAIN)
      && !hit(reg_addr, agd_pkg::ADDR_LEFT_DEB) && !hit(reg_addr, agd_pkg::ADDR_RIGHT_DEB)
      |=> reg_rvalid_r && reg_rdata_r == 8'h00)
      else $error("unmapped read not zero");
   rvalid_a: assert property (!reg_rd |=> !reg_rvalid_r)
      else $error("read valid without strobe");

endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
   localparam int TCYC = 8;
   logic mclk;
   logic rst;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata_r;
   logic reg_rvalid_r;
   logic [7:0] agc_gain;
   logic agc_gain_upd;
   logic double_rate_audio_mode;
   logic [1:0] noise_raw;
   logic [1:0] sig_det_status;
   int err_total = 0;
   int tests_run = 0;

   agd_top #(.TICK_CYC(TCYC)) dut (
      .mclk(mclk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r),
      .reg_rvalid_r(reg_rvalid_r),
      .agc_gain(agc_gain),
      .agc_gain_upd(agc_gain_upd),
      .double_rate_audio_mode(double_rate_audio_mode),
      .noise_raw(noise_raw),
      .sig_det_status(sig_det_status)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      check({7'h00, reg_rvalid_r}, 8'h01);
      check(reg_rdata_r, exp);
      cyc(1);
      check({7'h00, reg_rvalid_r}, 8'h00);
   endtask

   // Status must keep its old level until one tick before the debounce time runs out.
   task automatic deb(input int ch, input logic v, input int n, input int p);
      int lo;
      lo = (n - 1) * p - 2;
      noise_raw[ch] = v;
      if (lo > 0) begin
         cyc(lo);
         check({7'h00, sig_det_status[ch]}, {7'h00, ~v});
         cyc(n * p + 3 - lo);
      end else begin
         cyc((n == 0) ? 1 : n * p + 3);
      end
      check({7'h00, sig_det_status[ch]}, {7'h00, v});
   endtask

   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      agc_gain = 8'h00;
      agc_gain_upd = 1'b0;
      double_rate_audio_mode = 1'b0;
      noise_raw = 2'b00;
      cyc(16);
      rst = 1'b0;
      cyc(1);
      rd_chk(agd_pkg::ADDR_GAIN, 8'h00);
      rd_chk(agd_pkg::ADDR_LEFT_DEB, 8'h00);
      rd_chk(agd_pkg::ADDR_RIGHT_DEB, 8'h00);
      wr(agd_pkg::ADDR_LEFT_DEB, 8'hA5);
      wr(agd_pkg::ADDR_RIGHT_DEB, 8'h5A);
      wr(agd_pkg::ADDR_GAIN, 8'hFF);
      wr(8'h40, 8'h33);
      rd_chk(agd_pkg::ADDR_LEFT_DEB, 8'hA5);
      rd_chk(agd_pkg::ADDR_RIGHT_DEB, 8'h5A);
      rd_chk(agd_pkg::ADDR_GAIN, 8'h00);
      rd_chk(8'h40, 8'h00);
      agc_gain = 8'hE8;
      agc_gain_upd = 1'b1;
      cyc(1);
      agc_gain_upd = 1'b0;
      rd_chk(agd_pkg::ADDR_GAIN, 8'hE8);
      agc_gain = 8'h12;
      agc_gain_upd = 1'b1;
      cyc(1);
      agc_gain = 8'h77;
      cyc(1);
      agc_gain_upd = 1'b0;
      agc_gain = 8'h55;
      rd_chk(agd_pkg::ADDR_GAIN, 8'h77);
      wr(agd_pkg::ADDR_LEFT_DEB, 8'h00);
      wr(agd_pkg::ADDR_RIGHT_DEB, 8'h00);
      deb(0, 1'b1, 0, TCYC);
      deb(1, 1'b1, 0, TCYC);
      deb(0, 1'b0, 0, TCYC);
      deb(1, 1'b0, 0, TCYC);
      wr(agd_pkg::ADDR_LEFT_DEB, 8'h13);
      deb(0, 1'b1, 2, TCYC);
      deb(0, 1'b0, 4, TCYC);
      wr(agd_pkg::ADDR_RIGHT_DEB, 8'h0F);
      rd_chk(agd_pkg::ADDR_LEFT_DEB, 8'h13);
      deb(1, 1'b1, 1, TCYC);
      deb(1, 1'b0, 64, TCYC);
      wr(agd_pkg::ADDR_LEFT_DEB, 8'h40);
      deb(0, 1'b1, 128, TCYC);
      deb(0, 1'b0, 0, TCYC);
      wr(agd_pkg::ADDR_LEFT_DEB, 8'hF8);
      deb(0, 1'b1, 3072, TCYC);
      deb(0, 1'b0, 0, TCYC);
      double_rate_audio_mode = 1'b1;
      wr(agd_pkg::ADDR_LEFT_DEB, 8'h18);
      cyc(4);
      deb(0, 1'b1, 4, TCYC / 2);
      wrap_up();
   end

   // Longest planned path is about 26300 cycles.
   initial begin
      repeat (40000) @(posedge mclk);
      err_total++;
      wrap_up();
   end
endmodule

`default_nettype wire
